// [pkg/cies_map.svh]
// offsets, field positions, reset values, encodings and timing counts
// assumes a 100 MHz aclk and a byte-addressed AXI4-Lite register window
//
// Overview of operation
// - file move copies file f to working reg (d=0) or back to f (d=1)
// - file move sets zero flag from moved value for either destination
// - bank literal loads three-bit value into bank select, flags untouched
// - literal to working loads eight-bit value into working, flags untouched
// - option load copies working register into timer option, flags untouched
// - return with literal loads working with literal, counter from stack top
// - return with literal takes two instruction cycles, flags untouched
// - sleep clears the watchdog counter and its prescaler
// - sleep sets timeout status bit, leaves pin change wake flag alone
// - sleep clears the power down status bit
// - after sleep execution halts, oscillator stops until a wake event
// - rotate left through carry, result to working (d=0) or file (d=1)
`ifndef CIES_MAP_SVH
`define CIES_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define CIES_OFF_INSTR  8'h00
`define CIES_OFF_STATUS 8'h04
`define CIES_OFF_WREG   8'h08
`define CIES_OFF_OPTION 8'h0c
`define CIES_OFF_PC     8'h10
`define CIES_OFF_TOS    8'h14
`define CIES_OFF_WDT    8'h18
`define CIES_OFF_WAKE   8'h1c
`define CIES_OFF_FADDR  8'h20
`define CIES_OFF_FDATA  8'h24

// ----------------------------------------------------------------
// status and wake fields
// ----------------------------------------------------------------
`define CIES_ST_BUSY    0
`define CIES_ST_SLEEP   1
`define CIES_ST_CARRY   2
`define CIES_ST_ZERO    3
`define CIES_ST_TO      4
`define CIES_ST_PD      5
`define CIES_ST_PCWF    6
`define CIES_ST_BSR_LO  8
`define CIES_WK_WAKE    0
`define CIES_WK_PIN     1
`define CIES_WK_CLR     2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CIES_RST_OPTION 8'hff
`define CIES_RST_TO     1'b1
`define CIES_RST_PD     1'b1

// ----------------------------------------------------------------
// instruction class field, bits 11:8 of the instruction word
// ----------------------------------------------------------------
`define CIES_CLS_NOP    4'h0
`define CIES_CLS_SLEEP  4'h1
`define CIES_CLS_OPTION 4'h2
`define CIES_CLS_FILE_MOVE_OP   4'h3
`define CIES_CLS_RLF    4'h4
`define CIES_CLS_BANK_LITERAL_OP  4'h5
`define CIES_CLS_LITERAL_TO_WORKING_OP  4'h6
`define CIES_CLS_RETURN_WITH_LITERAL_OP  4'h7

// ----------------------------------------------------------------
// timing and bus answers
// ----------------------------------------------------------------
`define CIES_CLK_NS     10
`define CIES_TCY_NS     40
`define CIES_TCY_CLKS   (`CIES_TCY_NS / `CIES_CLK_NS)
`define CIES_RESP_OKAY  2'b00
`define CIES_RESP_SLV   2'b10

`endif

// [pkg/cies_pkg.sv]
// types shared by the execution core and its decoder
// assumes cies_map.svh for all numeric constants
package cies_pkg;

    typedef enum logic [3:0] {
        OP_NOP     = 4'b0000,
        OP_SLEEP   = 4'b0001,
        OP_OPTION  = 4'b0010,
        OP_FILE_MOVE_OP    = 4'b0011,
        OP_RLF     = 4'b0100,
        OP_BANK_LITERAL_OP   = 4'b0101,
        OP_LITERAL_TO_WORKING_OP   = 4'b0110,
        OP_RETURN_WITH_LITERAL_OP   = 4'b0111
    } cies_op_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_EXEC  = 2'b01,
        ST_RET2  = 2'b10,
        ST_SLEEP = 2'b11
    } cies_state_t;

    typedef logic [10:0] cies_pc_t;

    typedef struct packed {
        cies_op_t   op;
        logic       dest;
        logic [4:0] fsel;
        logic [7:0] lit;
    } cies_dec_t;

    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } cies_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } cies_axi_rsp_t;

endpackage

// [rtl/cies_core.sv]
// execution core for a small instruction subset behind an AXI4-Lite slave
// assumes one 100 MHz clock, synchronous active-low reset, one master
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`include "cies_map.svh"

module cies_core (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire cies_pkg::cies_axi_req_t axi_req,
    output cies_pkg::cies_axi_rsp_t      axi_rsp,
    output logic                         osc_run
);
    import cies_pkg::*;

    localparam logic [1:0] TCY_LAST = 2'(`CIES_TCY_CLKS - 1);

    cies_axi_rsp_t rsp_q;
    logic          aw_full_q;
    logic          w_full_q;
    logic [7:0]    waddr_q;
    logic [31:0]   wdata_q;
    logic [3:0]    wstrb_q;
    logic          wr_go;
    logic          wr_ok;
    logic          mapped;
    logic [31:0]   wmask;
    logic [31:0]   rd_data;
    logic          rd_hit;
    cies_state_t   state_q;
    logic [11:0]   instr_q;
    cies_dec_t     dec;
    logic [1:0]    tcy_q;
    logic          tick;
    logic          exec_go;
    logic          busy;
    logic [7:0]    w_q;
    logic [7:0]    option_q;
    logic [2:0]    bsr_q;
    logic          carry_q;
    logic          zero_q;
    logic          to_q;
    logic          pd_q;
    logic          pcwf_q;
    cies_pc_t      pc_q;
    cies_pc_t      tos_q;
    logic [7:0]    wdt_q;
    logic [7:0]    wdt_pre_q;
    logic          osc_q;
    logic [4:0]    faddr_q;
    logic [7:0]    file_mem [32];
    logic [7:0]    fval;
    logic [7:0]    result;
    logic          to_file;
    logic          to_w;
    logic          s_instr;
    logic          s_status;
    logic          s_wreg;
    logic          s_tos;
    logic          s_wake;
    logic          s_faddr;
    logic          s_fdata;
    logic          wake_go;
    logic          pin_set;
    logic          pin_clr;

    assign axi_rsp = rsp_q;
    assign osc_run = osc_q;

    cies_decode u_decode (
        .instr (instr_q),
        .dec   (dec)
    );

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    assign busy  = (state_q != ST_IDLE);
    assign wr_go = aw_full_q && w_full_q && !rsp_q.bvalid;
    assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                    {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    always_comb begin
        case (waddr_q)
            `CIES_OFF_INSTR, `CIES_OFF_STATUS, `CIES_OFF_WREG,
            `CIES_OFF_TOS, `CIES_OFF_FADDR, `CIES_OFF_FDATA:
                mapped = !busy;
            // wake stays reachable while asleep
            `CIES_OFF_WAKE: mapped = 1'b1;
            default:        mapped = 1'b0;
        endcase
    end

    assign wr_ok    = wr_go && mapped;
    assign s_instr  = wr_ok && (waddr_q == `CIES_OFF_INSTR);
    assign s_status = wr_ok && (waddr_q == `CIES_OFF_STATUS);
    assign s_wreg   = wr_ok && (waddr_q == `CIES_OFF_WREG);
    assign s_tos    = wr_ok && (waddr_q == `CIES_OFF_TOS);
    assign s_wake   = wr_ok && (waddr_q == `CIES_OFF_WAKE);
    assign s_faddr  = wr_ok && (waddr_q == `CIES_OFF_FADDR);
    assign s_fdata  = wr_ok && (waddr_q == `CIES_OFF_FDATA);

    assign pin_set = s_wake && wstrb_q[0] && (state_q == ST_SLEEP)
                     && wdata_q[`CIES_WK_PIN];
    assign pin_clr = s_wake && wstrb_q[0] && wdata_q[`CIES_WK_CLR];
    assign wake_go = s_wake && wstrb_q[0] && (state_q == ST_SLEEP)
                     && (wdata_q[`CIES_WK_WAKE] || wdata_q[`CIES_WK_PIN]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rsp_q.awready <= 1'b1;
            rsp_q.wready  <= 1'b1;
            rsp_q.bvalid  <= 1'b0;
            rsp_q.bresp   <= `CIES_RESP_OKAY;
            aw_full_q     <= 1'b0;
            w_full_q      <= 1'b0;
            waddr_q       <= 8'h00;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
        end else begin
            if (rsp_q.awready && axi_req.awvalid) begin
                rsp_q.awready <= 1'b0;
                aw_full_q     <= 1'b1;
                waddr_q       <= axi_req.awaddr;
            end
            if (rsp_q.wready && axi_req.wvalid) begin
                rsp_q.wready <= 1'b0;
                w_full_q     <= 1'b1;
                wdata_q      <= axi_req.wdata;
                wstrb_q      <= axi_req.wstrb;
            end
            if (wr_go) begin
                rsp_q.bvalid <= 1'b1;
                rsp_q.bresp  <= mapped ? `CIES_RESP_OKAY : `CIES_RESP_SLV;
            end
            if (rsp_q.bvalid && axi_req.bready) begin
                rsp_q.bvalid  <= 1'b0;
                rsp_q.awready <= 1'b1;
                rsp_q.wready  <= 1'b1;
                aw_full_q     <= 1'b0;
                w_full_q      <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (axi_req.araddr)
            `CIES_OFF_INSTR:  rd_data[11:0] = instr_q;
            `CIES_OFF_STATUS: begin
                rd_data[`CIES_ST_BUSY]  = busy;
                rd_data[`CIES_ST_SLEEP] = (state_q == ST_SLEEP);
                rd_data[`CIES_ST_CARRY] = carry_q;
                rd_data[`CIES_ST_ZERO]  = zero_q;
                rd_data[`CIES_ST_TO]    = to_q;
                rd_data[`CIES_ST_PD]    = pd_q;
                rd_data[`CIES_ST_PCWF]  = pcwf_q;
                rd_data[`CIES_ST_BSR_LO +: 3] = bsr_q;
            end
            `CIES_OFF_WREG:   rd_data[7:0]  = w_q;
            `CIES_OFF_OPTION: rd_data[7:0]  = option_q;
            `CIES_OFF_PC:     rd_data[10:0] = pc_q;
            `CIES_OFF_TOS:    rd_data[10:0] = tos_q;
            `CIES_OFF_WDT:    rd_data[7:0]  = wdt_q;
            `CIES_OFF_WAKE:   rd_data       = 32'h0000_0000;
            `CIES_OFF_FADDR:  rd_data[4:0]  = faddr_q;
            `CIES_OFF_FDATA:  rd_data[7:0]  = file_mem[faddr_q];
            default:          rd_hit        = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rsp_q.arready <= 1'b1;
            rsp_q.rvalid  <= 1'b0;
            rsp_q.rdata   <= 32'h0000_0000;
            rsp_q.rresp   <= `CIES_RESP_OKAY;
        end else if (rsp_q.arready && axi_req.arvalid) begin
            rsp_q.arready <= 1'b0;
            rsp_q.rvalid  <= 1'b1;
            rsp_q.rdata   <= rd_data;
            rsp_q.rresp   <= rd_hit ? `CIES_RESP_OKAY : `CIES_RESP_SLV;
        end else if (rsp_q.rvalid && axi_req.rready) begin
            rsp_q.rvalid  <= 1'b0;
            rsp_q.arready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // cycle divider, frozen while asleep, and sequencer
    // ----------------------------------------------------------------
    assign tick    = osc_q && (tcy_q == TCY_LAST);
    assign exec_go = (state_q == ST_EXEC) && tick;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tcy_q <= 2'd0;
        end else if (osc_q) begin
            tcy_q <= tick ? 2'd0 : tcy_q + 2'd1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            instr_q <= 12'h000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (s_instr) begin
                        state_q <= ST_EXEC;
                        instr_q <= (instr_q & ~wmask[11:0])
                                   | (wdata_q[11:0] & wmask[11:0]);
                    end
                end
                ST_EXEC: begin
                    if (exec_go) begin
                        case (dec.op)
                            OP_RETURN_WITH_LITERAL_OP: state_q <= ST_RET2;
                            OP_SLEEP: state_q <= ST_SLEEP;
                            default:  state_q <= ST_IDLE;
                        endcase
                    end
                end
                ST_RET2: begin
                    if (tick) state_q <= ST_IDLE;
                end
                ST_SLEEP: begin
                    if (wake_go) state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_q <= 1'b1;
        end else if (exec_go && dec.op == OP_SLEEP) begin
            osc_q <= 1'b0;
        end else if (wake_go) begin
            osc_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // data path
    // ----------------------------------------------------------------
    assign fval    = file_mem[dec.fsel];
    assign result  = (dec.op == OP_RLF) ? {fval[6:0], carry_q}
                                        : fval;
    assign to_file = exec_go && dec.dest
                     && (dec.op == OP_FILE_MOVE_OP || dec.op == OP_RLF);
    assign to_w    = exec_go && !dec.dest
                     && (dec.op == OP_FILE_MOVE_OP || dec.op == OP_RLF);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_q <= 8'h00;
        end else if (to_w) begin
            w_q <= result;
        end else if (exec_go && dec.op inside {OP_LITERAL_TO_WORKING_OP, OP_RETURN_WITH_LITERAL_OP}) begin
            w_q <= dec.lit;
        end else if (s_wreg) begin
            w_q <= (w_q & ~wmask[7:0]) | (wdata_q[7:0] & wmask[7:0]);
        end
    end

    always_ff @(posedge aclk) begin
        if (to_file) begin
            file_mem[dec.fsel] <= result;
        end else if (s_fdata && wstrb_q[0]) begin
            file_mem[faddr_q] <= wdata_q[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            faddr_q <= 5'd0;
        end else if (s_faddr && wstrb_q[0]) begin
            faddr_q <= wdata_q[4:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            option_q <= `CIES_RST_OPTION;
            bsr_q    <= 3'd0;
        end else if (exec_go && dec.op == OP_OPTION) begin
            option_q <= w_q;
        end else if (exec_go && dec.op == OP_BANK_LITERAL_OP) begin
            bsr_q    <= dec.lit[2:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            zero_q  <= 1'b0;
            carry_q <= 1'b0;
        end else if (exec_go && dec.op == OP_FILE_MOVE_OP) begin
            zero_q  <= (fval == 8'h00);
        end else if (exec_go && dec.op == OP_RLF) begin
            carry_q <= fval[7];
        end else if (s_status && wstrb_q[0]) begin
            zero_q  <= wdata_q[`CIES_ST_ZERO];
            carry_q <= wdata_q[`CIES_ST_CARRY];
        end
    end

    // ----------------------------------------------------------------
    // program counter, power status, free running watchdog
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_q <= 11'h000;
        end else if (exec_go && dec.op == OP_RETURN_WITH_LITERAL_OP) begin
            pc_q <= tos_q;
        end else if (exec_go) begin
            pc_q <= pc_q + 11'h001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tos_q <= 11'h000;
        end else if (s_tos) begin
            tos_q <= (tos_q & ~wmask[10:0])
                     | (wdata_q[10:0] & wmask[10:0]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            to_q <= `CIES_RST_TO;
            pd_q <= `CIES_RST_PD;
        end else if (exec_go && dec.op == OP_SLEEP) begin
            to_q <= 1'b1;
            pd_q <= 1'b0;
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pcwf_q <= 1'b0;
        end else if (pin_set) begin
            pcwf_q <= 1'b1;
        end else if (pin_clr) begin
            pcwf_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdt_pre_q <= 8'h00;
            wdt_q     <= 8'h00;
        end else if (exec_go && dec.op == OP_SLEEP) begin
            wdt_pre_q <= 8'h00;
            wdt_q     <= 8'h00;
        end else begin
            wdt_pre_q <= wdt_pre_q + 8'h01;
            wdt_q     <= wdt_q + {7'h00, &wdt_pre_q};
        end
    end

endmodule

// [rtl/cies_decode.sv]
// instruction word decoder, purely combinational
// assumes a 12-bit instruction word held stable by the core
`include "cies_map.svh"

module cies_decode (
    input  wire logic [11:0]      instr,
    output cies_pkg::cies_dec_t   dec
);
    import cies_pkg::*;

    always_comb begin
        dec.dest = instr[5];
        dec.fsel = instr[4:0];
        dec.lit  = instr[7:0];
        case (instr[11:8])
            `CIES_CLS_SLEEP:  dec.op = OP_SLEEP;
            `CIES_CLS_OPTION: dec.op = OP_OPTION;
            `CIES_CLS_FILE_MOVE_OP:   dec.op = OP_FILE_MOVE_OP;
            `CIES_CLS_RLF:    dec.op = OP_RLF;
            `CIES_CLS_BANK_LITERAL_OP:  dec.op = OP_BANK_LITERAL_OP;
            `CIES_CLS_LITERAL_TO_WORKING_OP:  dec.op = OP_LITERAL_TO_WORKING_OP;
            `CIES_CLS_RETURN_WITH_LITERAL_OP:  dec.op = OP_RETURN_WITH_LITERAL_OP;
            // unknown classes behave as no operation
            default:          dec.op = OP_NOP;
        endcase
    end

endmodule

// [tb/cies_core_properties.sv]
// concurrent checks on the execution core's bus and oscillator ports
// assumes binding onto cies_core, offsets and classes from cies_map.svh
`include "cies_map.svh"

module cies_properties (
    input wire logic                    aclk,
    input wire logic                    aresetn,
    input wire cies_pkg::cies_axi_req_t axi_req,
    input wire cies_pkg::cies_axi_rsp_t axi_rsp,
    input wire logic                    osc_run
);
    import cies_pkg::*;
    logic [7:0] wa_q;
    logic [3:0] wc_q;
    logic [7:0] ra_q;
    logic       slp_q;
    logic       aw_hs;
    logic       w_hs;
    logic       ar_hs;
    assign aw_hs = axi_req.awvalid & axi_rsp.awready;
    assign w_hs  = axi_req.wvalid & axi_rsp.wready;
    assign ar_hs = axi_req.arvalid & axi_rsp.arready;
    // ----------------------------------------------------------------
    // last addresses, last class, sleep requested
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wa_q  <= 8'h00;
            wc_q  <= 4'h0;
            ra_q  <= 8'h00;
            slp_q <= 1'b0;
        end else begin
            if (aw_hs) wa_q <= axi_req.awaddr;
            if (w_hs) wc_q <= axi_req.wdata[11:8];
            if (ar_hs) ra_q <= axi_req.araddr;
            if (aw_hs && w_hs && axi_req.awaddr == `CIES_OFF_INSTR) begin
                slp_q <= axi_req.wdata[11:8] == `CIES_CLS_SLEEP;
            end
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_read_latency: assert property (ar_hs |=> axi_rsp.rvalid)
        else $error("read answer not one cycle after address");
    chk_write_latency: assert property (aw_hs && w_hs
        |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid)
        else $error("write answer not two cycles after address");
    chk_rdata_hold: assert property (axi_rsp.rvalid && !axi_req.rready
        |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read data dropped before ready");
    chk_sleep_status: assert property ($rose(axi_rsp.rvalid) &&
        ra_q == `CIES_OFF_STATUS && !$past(osc_run)
        |-> axi_rsp.rdata[5:4] == 2'b01 && axi_rsp.rdata[1])
        else $error("status wrong while asleep");
    chk_sleep_fall: assert property ($fell(osc_run) |-> slp_q)
        else $error("oscillator stopped without sleep");
    chk_sleep_enter: assert property ($rose(axi_rsp.bvalid) &&
        wa_q == `CIES_OFF_INSTR && wc_q == `CIES_CLS_SLEEP &&
        axi_rsp.bresp == `CIES_RESP_OKAY |-> ##[1:5] !osc_run)
        else $error("oscillator still running after sleep");
    chk_wake_run: assert property (aw_hs && w_hs &&
        axi_req.awaddr == `CIES_OFF_WAKE && |axi_req.wdata[1:0]
        |-> ##[1:6] osc_run)
        else $error("oscillator not restarted by wake");
    chk_readonly_refused: assert property ($rose(axi_rsp.bvalid) &&
        wa_q inside {`CIES_OFF_OPTION, `CIES_OFF_PC, `CIES_OFF_WDT}
        |-> axi_rsp.bresp == `CIES_RESP_SLV)
        else $error("read-only write accepted");
    chk_unmapped_read: assert property ($rose(axi_rsp.rvalid) &&
        ra_q > `CIES_OFF_FDATA |-> axi_rsp.rresp == `CIES_RESP_SLV &&
        axi_rsp.rdata == 32'h0)
        else $error("unmapped read accepted");
    cov_sleep: cover property ($fell(osc_run));
    cov_wake: cover property ($rose(osc_run));
    cov_refused: cover property (axi_rsp.bvalid &&
        axi_rsp.bresp == `CIES_RESP_SLV);
endmodule

bind cies_core cies_properties cies_properties_inst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .axi_req (axi_req),
    .axi_rsp (axi_rsp),
    .osc_run (osc_run)
);

// [tb/testbench.sv]
// self-checking bench driving the core through its register bus
// assumes cies_core, cies_map.svh offsets, 100 MHz aclk
`include "cies_map.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import cies_pkg::*;
    logic          aclk;
    logic          aresetn;
    cies_axi_req_t req;
    cies_axi_rsp_t rsp;
    logic          osc_run;
    int            miscompares;
    int            checks;
    int            cyc = 0;
    int            seed;
    logic [31:0]   rv;
    logic [1:0]    rr;
    logic          b1;

    cies_core cies_core_inst (
        .aclk    (aclk),
        .aresetn (aresetn),
        .axi_req (req),
        .axi_rsp (rsp),
        .osc_run (osc_run)
    );

    always #5 aclk = ~aclk;

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            miscompares = miscompares + 1;
            conclude();
        end
    end
    // ----------------------------------------------------------------
    // bus tasks and expectations
    // ----------------------------------------------------------------
    task automatic conclude();
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        req.awaddr <= a;
        req.wdata <= d;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && rsp.awready === 1'b1) begin
                aw = 1'b0;
                req.awvalid <= 1'b0;
            end
            if (w && rsp.wready === 1'b1) begin
                w = 1'b0;
                req.wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (rsp.bvalid !== 1'b1);
        rr = rsp.bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        do @(posedge aclk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        @(posedge aclk);
        req.rready <= 1'b1;
        do @(posedge aclk); while (rsp.rvalid !== 1'b1);
        rv = rsp.rdata;
        rr = rsp.rresp;
        req.rready <= 1'b0;
    endtask
    task automatic run(input logic [11:0] ins);
        wr(`CIES_OFF_INSTR, {20'h0, ins});
        rd(`CIES_OFF_STATUS);
        b1 = rv[`CIES_ST_BUSY];
        while (rv[`CIES_ST_BUSY] !== 1'b0) rd(`CIES_OFF_STATUS);
    endtask
    task automatic prep(input logic [4:0] f, input logic [7:0] v,
                        input logic [7:0] w, input logic [1:0] zc);
        wr(`CIES_OFF_FADDR, {27'h0, f});
        wr(`CIES_OFF_FDATA, {24'h0, v});
        wr(`CIES_OFF_WREG, {24'h0, w});
        wr(`CIES_OFF_STATUS, {28'h0, zc, 2'b00});
    endtask
    function automatic logic [8:0] rot_left(input logic [7:0] v,
                                            input logic c);
        return {v, c};
    endfunction

    initial begin
        logic [31:0] rnd;
        logic [31:0] stx;
        logic [8:0]  e9;
        logic [7:0]  v;
        logic [7:0]  w0;
        logic [7:0]  k;
        logic [4:0]  f;
        logic [10:0] t;
        logic        d;
        logic        c;
        logic        z;
        aclk = 1'b0;
        aresetn = 1'b0;
        req = '0;
        req.wstrb = 4'hf;
        req.bready = 1'b1;
        miscompares = 0;
        checks = 0;
        seed = 32'h0939;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`CIES_OFF_OPTION);
        cmp(rv, 32'h0000_00ff);
        rd(`CIES_OFF_STATUS);
        cmp(rv, 32'h0000_0030);
        rd(8'h40);
        cmp({rv[29:0], rr}, {30'h0, `CIES_RESP_SLV});
        wr(`CIES_OFF_OPTION, 32'h0);
        cmp(rr, `CIES_RESP_SLV);
        for (int i = 0; i < 8; i++) begin
            rnd = $random(seed);
            {k, z, c, d, f, w0, v} = rnd;
            if (i == 0) v = 8'h00;
            if (i == 1) f = 5'd31;
            t = {k[2:0], v};
            prep(f, v, w0, {v != 8'h00, c});
            run({4'h3, 2'b00, d, f});
            rd(`CIES_OFF_WREG);
            cmp(rv, {24'h0, d ? w0 : v});
            rd(`CIES_OFF_FDATA);
            cmp(rv, {24'h0, v});
            rd(`CIES_OFF_STATUS);
            cmp(rv[3:2], {v == 8'h00, c});
            prep(f, v, w0, {z, c});
            run({4'h4, 2'b00, d, f});
            e9 = rot_left(v, c);
            rd(`CIES_OFF_WREG);
            cmp(rv, {24'h0, d ? w0 : e9[7:0]});
            rd(`CIES_OFF_FDATA);
            cmp(rv, {24'h0, d ? e9[7:0] : v});
            rd(`CIES_OFF_STATUS);
            cmp(rv[3:2], {z, e9[8]});
            stx = {rv[31:11], k[2:0], rv[7:0]};
            run({4'h5, k});
            cmp(rv, stx);
            run({4'h6, k});
            cmp(rv, stx);
            rd(`CIES_OFF_WREG);
            cmp(rv, {24'h0, k});
            run(12'h200);
            cmp(rv, stx);
            rd(`CIES_OFF_OPTION);
            cmp(rv, {24'h0, k});
            wr(`CIES_OFF_TOS, {21'h0, t});
            run({4'h7, v});
            cmp(b1, 1'b1);
            cmp(rv, stx);
            run(12'h000);
            rd(`CIES_OFF_PC);
            cmp(rv, {21'h0, t + 11'h001});
            rd(`CIES_OFF_WREG);
            cmp(rv, {24'h0, v});
            run({i[0] ? 4'h0 : {1'b1, k[2:0]}, 8'h00});
            cmp(rv, stx);
        end
        wr(`CIES_OFF_WAKE, 32'h0000_0002);
        rd(`CIES_OFF_WDT);
        cmp(rv == 32'h0, 1'b0);
        for (int j = 0; j < 2; j++) begin
            rd(`CIES_OFF_PC);
            stx = rv + 32'h1;
            wr(`CIES_OFF_INSTR, 32'h0000_0100);
            do rd(`CIES_OFF_STATUS); while (rv[`CIES_ST_SLEEP] !== 1'b1);
            cmp({rv[6:4], osc_run}, {j[0], 3'b010});
            rd(`CIES_OFF_WDT);
            cmp(rv, 32'h0);
            rd(`CIES_OFF_PC);
            cmp(rv, stx);
            wr(`CIES_OFF_INSTR, 32'h0000_065a);
            cmp(rr, `CIES_RESP_SLV);
            wr(`CIES_OFF_WAKE, j ? 32'h1 : 32'h2);
            do rd(`CIES_OFF_STATUS); while (rv[`CIES_ST_SLEEP] !== 1'b0);
        end
        rd(`CIES_OFF_WREG);
        cmp({rv[7:0], osc_run}, {v, 1'b1});
        conclude();
    end
endmodule
